// [rtl/ioa_top.sv]
// I/O adapter: two ports, two timers, shifter, interrupts, APB registers
`timescale 1ns/1ps
module ioa_top #(
  parameter int TW = 16
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0] pstrb,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic [7:0] port_a_lines_in,
  output logic [7:0]      port_a_lines_out,
  output logic [7:0]      port_a_lines_oe_n,
  input  wire logic [7:0] port_b_lines_in,
  output logic [7:0]      port_b_lines_out,
  output logic [7:0]      port_b_lines_oe_n,
  input  wire logic       ca1,
  output logic            ca2,
  input  wire logic       cb1,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            irq
);
  import ioa_pkg::*;

  logic [7:0]    ora_q, orb_q, port_a_direction_q, port_b_direction_q, ira_q, irb_q;
  logic          lat_a_q, lat_b_q;
  logic [7:0]    aux_q, pctl_q, flags_q, enab_q, shift_q;
  logic [TW-1:0] t1_q, t2_q;
  logic [7:0]    t1l_lo_q, t1l_hi_q, t2l_lo_q;
  logic          t1_arm_q, t2_arm_q, ca1_q, cb1_q, ca2_q;
  logic [2:0]    sr_cnt_q;
  ioa_sr_state_t sr_st_q;
  logic [31:0]   prdata_q;
  logic          pready_q, pslverr_q, irq_q;
  logic [7:0]    rdat, set_flags, clr_flags;
  logic          ca1_edge, cb1_edge, t1_zero, t2_zero, t2_tick;
  logic          wr_done, rd_done, map_ok;
  logic [3:0]    idx;

  // Edge of a control input in the chosen polarity
  function automatic logic edge_hit(logic now, logic prev, logic pos);
    return pos ? (now & ~prev) : (~now & prev);
  endfunction

  // Bus word index; bits outside the map answer with an error
  assign idx     = paddr[5:2];
  assign map_ok  = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00);
  assign wr_done = psel & penable & pready_q & pwrite & map_ok & pstrb[0];
  assign rd_done = psel & penable & pready_q & ~pwrite & map_ok;

  assign ca1_edge = edge_hit(ca1, ca1_q, pctl_q[PCR_CA1_POS]);
  assign cb1_edge = edge_hit(cb1, cb1_q, pctl_q[PCR_CB1_POS]);
  assign t1_zero  = (t1_q == '0);
  assign t2_zero  = (t2_q == '0);
  // Pulse mode counts cb1 edges, interval mode counts clocks
  assign t2_tick  = aux_q[AUX_T2_PULS] ? cb1_edge : 1'b1;

  // Read data mux
  always_comb
  begin
    rdat = RST_BYTE;
    if (idx == IDX_PB)
      rdat = (orb_q & port_b_direction_q) | (~port_b_direction_q & (lat_b_q ? irb_q : port_b_lines_in));
    else if (idx == IDX_PA || idx == IDX_PANH)
      rdat = lat_a_q ? ira_q : port_a_lines_in;
    else if (idx == IDX_PORT_B_DIRECTION)
      rdat = port_b_direction_q;
    else if (idx == IDX_PORT_A_DIRECTION)
      rdat = port_a_direction_q;
    else if (idx == IDX_T1CL)
      rdat = t1_q[7:0];
    else if (idx == IDX_T1CH)
      rdat = t1_q[15:8];
    else if (idx == IDX_T1LL)
      rdat = t1l_lo_q;
    else if (idx == IDX_T1LH)
      rdat = t1l_hi_q;
    else if (idx == IDX_T2CL)
      rdat = t2_q[7:0];
    else if (idx == IDX_T2CH)
      rdat = t2_q[15:8];
    else if (idx == IDX_SHIFT)
      rdat = shift_q;
    else if (idx == IDX_AUX)
      rdat = aux_q;
    else if (idx == IDX_PCTL)
      rdat = pctl_q;
    else if (idx == IDX_FLAGS)
      rdat = {|(flags_q[6:0] & enab_q[6:0]), flags_q[6:0]};
    else
      rdat = enab_q;
  end

  // APB answer: no wait states, data latched during setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready_q  <= 1'b1;
      pslverr_q <= ~map_ok;
      prdata_q  <= {24'h00_0000, map_ok ? rdat : RST_BYTE};
    end
    else
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Port output, direction and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ora_q  <= RST_BYTE;
      orb_q  <= RST_BYTE;
      port_a_direction_q <= RST_BYTE;
      port_b_direction_q <= RST_BYTE;
      aux_q  <= RST_BYTE;
      pctl_q <= RST_BYTE;
      enab_q <= RST_BYTE;
    end
    else if (wr_done)
    begin
      if (idx == IDX_PB)
        orb_q <= pwdata[7:0];
      else if (idx == IDX_PA || idx == IDX_PANH)
        ora_q <= pwdata[7:0];
      else if (idx == IDX_PORT_B_DIRECTION)
        port_b_direction_q <= pwdata[7:0];
      else if (idx == IDX_PORT_A_DIRECTION)
        port_a_direction_q <= pwdata[7:0];
      else if (idx == IDX_AUX)
        aux_q <= pwdata[7:0];
      else if (idx == IDX_PCTL)
        pctl_q <= pwdata[7:0];
      else if (idx == IDX_ENAB)
        enab_q <= pwdata[7:0];
    end
  end

  // Input latches; reading the port reopens the latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ira_q   <= RST_BYTE;
      irb_q   <= RST_BYTE;
      lat_a_q <= 1'b0;
      lat_b_q <= 1'b0;
      ca1_q   <= 1'b0;
      cb1_q   <= 1'b0;
    end
    else
    begin
      ca1_q <= ca1;
      cb1_q <= cb1;
      if (ca1_edge && aux_q[AUX_LATCH_A])
      begin
        ira_q   <= port_a_lines_in;
        lat_a_q <= 1'b1;
      end
      else if (rd_done && (idx == IDX_PA || idx == IDX_PANH))
        lat_a_q <= 1'b0;
      if (cb1_edge && aux_q[AUX_LATCH_B])
      begin
        irb_q   <= port_b_lines_in;
        lat_b_q <= 1'b1;
      end
      else if (rd_done && idx == IDX_PB)
        lat_b_q <= 1'b0;
    end
  end

  // Handshake line: access via code one drops it, ca1 edge raises it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ca2_q <= 1'b1;
    else if (ca1_edge)
      ca2_q <= 1'b1;
    else if ((wr_done || rd_done) && idx == IDX_PA)
      ca2_q <= 1'b0;
  end

  // Timer one: latches, load on high write, one-shot or free run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t1_q     <= '1;
      t1l_lo_q <= RST_LTCH;
      t1l_hi_q <= RST_LTCH;
      t1_arm_q <= 1'b0;
    end
    else
    begin
      if (wr_done && (idx == IDX_T1CL || idx == IDX_T1LL))
        t1l_lo_q <= pwdata[7:0];
      if (wr_done && (idx == IDX_T1CH || idx == IDX_T1LH))
        t1l_hi_q <= pwdata[7:0];
      if (wr_done && idx == IDX_T1CH)
      begin
        t1_q     <= {pwdata[7:0], t1l_lo_q};
        t1_arm_q <= 1'b1;
      end
      else if (t1_zero && aux_q[AUX_T1_FREE])
        t1_q <= {t1l_hi_q, t1l_lo_q};
      else
      begin
        t1_q <= t1_q - 1'b1;
        if (t1_zero)
          t1_arm_q <= 1'b0;
      end
    end
  end

  // Timer two: interval or pulse counter, one interrupt per load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t2_q     <= '1;
      t2l_lo_q <= RST_LTCH;
      t2_arm_q <= 1'b0;
    end
    else
    begin
      if (wr_done && idx == IDX_T2CL)
        t2l_lo_q <= pwdata[7:0];
      if (wr_done && idx == IDX_T2CH)
      begin
        t2_q     <= {pwdata[7:0], t2l_lo_q};
        t2_arm_q <= 1'b1;
      end
      else if (t2_tick)
      begin
        t2_q <= t2_q - 1'b1;
        if (t2_zero)
          t2_arm_q <= 1'b0;
      end
    end
  end

  // Shifter: eight bits per access, in or out per aux bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q  <= RST_BYTE;
      sr_cnt_q <= 3'd0;
      sr_st_q  <= SR_IDLE;
    end
    else
    begin
      case (sr_st_q)
        SR_IDLE:
        begin
          if (wr_done && idx == IDX_SHIFT)
            shift_q <= pwdata[7:0];
          // Any access starts a byte when the shifter is enabled
          if ((wr_done || rd_done) && idx == IDX_SHIFT && aux_q[AUX_SR_EN])
          begin
            sr_st_q  <= SR_SHIFT;
            sr_cnt_q <= 3'd0;
          end
        end
        SR_SHIFT:
        begin
          shift_q  <= {shift_q[6:0], aux_q[AUX_SR_OUT] ? shift_q[7] : serial_in};
          sr_cnt_q <= sr_cnt_q + 3'd1;
          if (sr_cnt_q == 3'd7)
            sr_st_q <= SR_IDLE;
        end
        default:
          sr_st_q <= SR_IDLE;
      endcase
    end
  end

  // Serial output bit, held from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_out <= 1'b0;
    else
      serial_out <= shift_q[7];
  end

  // Flag events; set wins over clear
  always_comb
  begin
    set_flags = RST_BYTE;
    set_flags[FLG_CA1] = ca1_edge;
    set_flags[FLG_CB1] = cb1_edge;
    set_flags[FLG_T1]  = t1_zero & t1_arm_q;
    set_flags[FLG_T2]  = t2_zero & t2_arm_q & t2_tick;
    set_flags[FLG_SR]  = (sr_st_q == SR_SHIFT) && (sr_cnt_q == 3'd7);
    clr_flags = RST_BYTE;
    if (wr_done && idx == IDX_FLAGS)
      clr_flags = pwdata[7:0];
    if ((wr_done || rd_done) && idx == IDX_PA)
      clr_flags[FLG_CA1] = 1'b1;
    if ((wr_done || rd_done) && idx == IDX_PB)
      clr_flags[FLG_CB1] = 1'b1;
    if ((wr_done && idx == IDX_T1CH) || (rd_done && idx == IDX_T1CL))
      clr_flags[FLG_T1] = 1'b1;
    if ((wr_done && idx == IDX_T2CH) || (rd_done && idx == IDX_T2CL))
      clr_flags[FLG_T2] = 1'b1;
    if ((wr_done || rd_done) && idx == IDX_SHIFT)
      clr_flags[FLG_SR] = 1'b1;
  end

  // Sticky flags and interrupt level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= RST_BYTE;
      irq_q   <= 1'b0;
    end
    else
    begin
      flags_q <= ((flags_q & ~clr_flags) | set_flags) & 8'h7F;
      irq_q   <= |(((flags_q & ~clr_flags) | set_flags) & enab_q & 8'h7F);
    end
  end

  // Outputs from flops; the port output enables are the inverted direction flops
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign port_a_lines_out  = ora_q;
  assign port_a_lines_oe_n = ~port_a_direction_q;
  assign port_b_lines_out  = orb_q;
  assign port_b_lines_oe_n = ~port_b_direction_q;
  assign ca2               = ca2_q;
  assign irq               = irq_q;
endmodule

// [rtl/ioa_pkg.sv]
// Shared constants for the I/O adapter register bank
package ioa_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_PB    = 4'h0;
  localparam logic [3:0] IDX_PA    = 4'h1;
  localparam logic [3:0] IDX_PORT_B_DIRECTION  = 4'h2;
  localparam logic [3:0] IDX_PORT_A_DIRECTION  = 4'h3;
  localparam logic [3:0] IDX_T1CL  = 4'h4;
  localparam logic [3:0] IDX_T1CH  = 4'h5;
  localparam logic [3:0] IDX_T1LL  = 4'h6;
  localparam logic [3:0] IDX_T1LH  = 4'h7;
  localparam logic [3:0] IDX_T2CL  = 4'h8;
  localparam logic [3:0] IDX_T2CH  = 4'h9;
  localparam logic [3:0] IDX_SHIFT = 4'hA;
  localparam logic [3:0] IDX_AUX   = 4'hB;
  localparam logic [3:0] IDX_PCTL  = 4'hC;
  localparam logic [3:0] IDX_FLAGS = 4'hD;
  localparam logic [3:0] IDX_ENAB  = 4'hE;
  localparam logic [3:0] IDX_PANH  = 4'hF;
  // Auxiliary control fields
  localparam int AUX_LATCH_A = 0;
  localparam int AUX_LATCH_B = 1;
  localparam int AUX_SR_EN   = 2;
  localparam int AUX_SR_OUT  = 4;
  localparam int AUX_T2_PULS = 5;
  localparam int AUX_T1_FREE = 6;
  // Peripheral control fields
  localparam int PCR_CA1_POS = 0;
  localparam int PCR_CB1_POS = 4;
  // Interrupt flag positions
  localparam int FLG_CA1   = 1;
  localparam int FLG_SR    = 2;
  localparam int FLG_CB1   = 4;
  localparam int FLG_T2    = 5;
  localparam int FLG_T1    = 6;
  localparam int FLG_ANY   = 7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LTCH = 8'hFF;
  // Shifter state
  typedef enum logic [1:0] {
    SR_IDLE  = 2'b01,
    SR_SHIFT = 2'b10
  } ioa_sr_state_t;
endpackage

// [tb/ioa_properties.sv]
// Concurrent checks on the adapter bus and pin behaviour
`timescale 1ns/1ps
module ioa_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_a_lines_out,
  input wire logic [7:0]  port_a_lines_oe_n,
  input wire logic [7:0]  port_b_lines_out,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Write that completes at this edge with the low lane on
  sequence wr_at(logic [11:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready && !pwrite && paddr[11:6] != 6'h00 |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_dir_a: assert property (wr_at(12'h00C) |=> port_a_lines_oe_n == ~$past(pwdata[7:0]))
    else $error("port A direction not applied");
  a_alias_out: assert property (wr_at(12'h03C) |=> port_a_lines_out == $past(pwdata[7:0]))
    else $error("alias write missed port A");
  a_pb_out: assert property (wr_at(12'h000) |=> port_b_lines_out == $past(pwdata[7:0]))
    else $error("port B output not written");
  a_irq_masked: assert property (wr_at(12'h038) ##0 pwdata[6:0] == 7'h00 |=> ##1 !irq)
    else $error("irq with all sources masked");
endmodule

// [tb/ioa_pin_model.sv]
// Peripheral side of one port: resolves each line from both drivers
`timescale 1ns/1ps
module ioa_pin_model (
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] ext,
  output logic [7:0]      pins
);
  // Peripheral drives only the lines the adapter leaves as inputs
  assign pins = (drv & ~oe_n) | (ext & oe_n);
endmodule

// [tb/testbench.sv]
// Bench for the adapter registers, ports, timers and shifter
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        ca1 = 0, cb1 = 0, serial_in = 0, ev;
  logic        pready, pslverr, ca2, serial_out, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  port_a_lines_in, port_a_lines_out, port_a_lines_oe_n, ext_a = '0;
  logic [7:0]  port_b_lines_in, port_b_lines_out, port_b_lines_oe_n, ext_b = '0;
  int          num_errors = 0, n_checks = 0, cyc = 0, wc;
  // Bus clock, 10 ns period
  always #5 pclk = ~pclk;
  ioa_top u_dut (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .port_a_lines_in   (port_a_lines_in),
    .port_a_lines_out  (port_a_lines_out),
    .port_a_lines_oe_n (port_a_lines_oe_n),
    .port_b_lines_in   (port_b_lines_in),
    .port_b_lines_out  (port_b_lines_out),
    .port_b_lines_oe_n (port_b_lines_oe_n),
    .ca1               (ca1),
    .ca2               (ca2),
    .cb1               (cb1),
    .serial_in         (serial_in),
    .serial_out        (serial_out),
    .irq               (irq)
  );
  // Peripheral models on both ports
  ioa_pin_model u_pa (.drv(port_a_lines_out), .oe_n(port_a_lines_oe_n), .ext(ext_a), .pins(port_a_lines_in));
  ioa_pin_model u_pb (.drv(port_b_lines_out), .oe_n(port_b_lines_oe_n), .ext(ext_b), .pins(port_b_lines_in));
  // Compare, four-state so an unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for ready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    // Ready and read data are taken at the same rising edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      num_errors++;
    rdv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
  // Bounded wait for the interrupt line to reach a level
  task automatic wirq(input logic v, input int lim);
    wc = 0;
    @(negedge pclk);
    while (irq !== v && wc < lim)
    begin
      @(negedge pclk);
      wc++;
    end
    @(posedge pclk);
  endtask
  // Mixed directions, pins resolved by the models, refused addresses
  task automatic t_ports;
    ext_a <= 8'h3C;
    apb(1, 12'h00C, 8'hF0);
    apb(1, 12'h004, 8'hA5);
    chk(port_a_lines_oe_n, 8'h0F);
    apb(0, 12'h004, 8'h00);
    chk(rdv, 8'hAC);
    apb(1, 12'h000, 8'h3C);
    chk(port_b_lines_out, 8'h3C);
    apb(0, 12'h040, 8'h00);
    chk(ev, 1'b1);
    apb(1, 12'h006, 8'h00);
    chk(ev, 1'b1);
  endtask
  // Code fifteen reaches port A but leaves handshake and flag alone
  task automatic t_alias;
    apb(1, 12'h004, 8'h5A);
    chk(ca2, 1'b0);
    apb(1, 12'h030, 8'h01);
    ca1 <= 1;
    repeat (3) @(posedge pclk);
    chk(ca2, 1'b1);
    apb(1, 12'h03C, 8'hC3);
    chk(port_a_lines_out, 8'hC3);
    chk(ca2, 1'b1);
    apb(0, 12'h034, 8'h00);
    chk(rdv & 32'h0000_0002, 8'h02);
    apb(0, 12'h004, 8'h00);
    apb(0, 12'h034, 8'h00);
    chk(rdv & 32'h0000_0002, 8'h00);
  endtask
  // Input latch holds the pins of the edge, then turns transparent
  task automatic t_latch;
    apb(1, 12'h00C, 8'h00);
    apb(1, 12'h02C, 8'h01);
    ca1 <= 0;
    ext_a <= 8'h11;
    repeat (3) @(posedge pclk);
    ca1 <= 1;
    repeat (3) @(posedge pclk);
    ext_a <= 8'h22;
    apb(0, 12'h004, 8'h00);
    chk(rdv, 8'h11);
    apb(0, 12'h004, 8'h00);
    chk(rdv, 8'h22);
    apb(1, 12'h02C, 8'h00);
  endtask
  // Timer one: one-shot on a 16-bit count, then evenly spaced free-run
  task automatic t_timer1;
    int w1;
    apb(1, 12'h038, 8'h40);
    apb(1, 12'h010, 8'h00);
    apb(1, 12'h014, 8'h01);
    wirq(1'b1, 400);
    chk(wc > 250, 1'b1);
    chk(irq, 1'b1);
    apb(0, 12'h010, 8'h00);
    wirq(1'b1, 300);
    chk(irq, 1'b0);
    apb(1, 12'h02C, 8'h40);
    apb(1, 12'h010, 8'h30);
    apb(1, 12'h014, 8'h00);
    wirq(1'b1, 400);
    apb(1, 12'h034, 8'h40);
    wirq(1'b1, 400);
    w1 = wc;
    apb(1, 12'h034, 8'h40);
    wirq(1'b1, 400);
    chk(irq, 1'b1);
    chk(wc, w1);
    apb(1, 12'h038, 8'h00);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1, 12'h02C, 8'h00);
  endtask
  // Timer two counts input edges; flag on the edge that passes zero
  task automatic t_timer2;
    apb(1, 12'h02C, 8'h20);
    apb(1, 12'h030, 8'h10);
    apb(1, 12'h020, 8'h03);
    apb(1, 12'h024, 8'h00);
    repeat (4)
    begin
      apb(0, 12'h034, 8'h00);
      chk(rdv & 32'h0000_0020, 8'h00);
      cb1 <= 1;
      repeat (3) @(posedge pclk);
      cb1 <= 0;
      repeat (3) @(posedge pclk);
    end
    apb(0, 12'h034, 8'h00);
    chk(rdv & 32'h0000_0020, 8'h20);
  endtask
  // Shifter sends a byte out and flags completion
  task automatic t_shift;
    apb(1, 12'h02C, 8'h14);
    apb(1, 12'h028, 8'h96);
    @(negedge pclk);
    chk(serial_out, 1'b1);
    @(negedge pclk);
    chk(serial_out, 1'b0);
    repeat (20) @(posedge pclk);
    apb(0, 12'h034, 8'h00);
    chk(rdv & 32'h0000_0004, 8'h04);
    apb(0, 12'h028, 8'h00);
    chk(rdv, 8'h96);
  endtask
  // Verdict and end of run
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence after five reset cycles
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(port_a_lines_oe_n, 8'hFF);
    t_ports;
    t_alias;
    t_latch;
    t_timer1;
    t_timer2;
    t_shift;
    final_report;
  end
  // Hang guard well above the expected run length
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report;
    end
  end
endmodule
bind ioa_top ioa_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_a_lines_out(port_a_lines_out), .port_a_lines_oe_n(port_a_lines_oe_n),
  .port_b_lines_out(port_b_lines_out), .irq(irq));
